/* File: shared/dac_monitor_pkg.sv */
// Shared constants for the channel D word and mode configuration block.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
package dac_monitor_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_DAC_D_LOW = 8'h16;
   localparam logic [7:0] IDX_DAC_D_HIGH = 8'h17;
   localparam logic [7:0] IDX_MODE_CFG_ONE = 8'h18;
   localparam logic [7:0] IDX_MODE_CFG_TWO = 8'h19;
   localparam logic [7:0] IDX_STATUS = 8'h20;
   localparam logic [7:0] ADDR_DAC_D_LOW = IDX_DAC_D_LOW << 2;
   localparam logic [7:0] ADDR_DAC_D_HIGH = IDX_DAC_D_HIGH << 2;
   localparam logic [7:0] ADDR_MODE_CFG_ONE = IDX_MODE_CFG_ONE << 2;
   localparam logic [7:0] ADDR_MODE_CFG_TWO = IDX_MODE_CFG_TWO << 2;
   localparam logic [7:0] ADDR_STATUS = IDX_STATUS << 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   // Reset values
   localparam logic [7:0] RST_DAC_D_LOW = 8'h00;
   localparam logic [7:0] RST_DAC_D_HIGH = 8'h00;
   localparam logic [7:0] RST_MODE_CFG_ONE = 8'h00;
   localparam logic [7:0] RST_MODE_CFG_TWO = 8'h00;
   // Mode configuration one fields
   localparam int CFG1_MONITOR_BIT = 0;
   localparam int CFG1_INT_DISABLE_BIT = 5;
   localparam int CFG1_INT_POLARITY_BIT = 6;
   localparam int CFG1_STANDBY_BIT = 7;
   // Mode configuration two fields
   localparam int CFG2_CHAN_LSB = 0;
   localparam int CFG2_SINGLE_BIT = 4;
   localparam int CFG2_AVG_OFF_BIT = 5;
   localparam int CFG2_TIMEOUT_BIT = 6;
   localparam int CFG2_SWRESET_BIT = 7;
   // Status fields
   localparam int STAT_CHAN_LSB = 0;
   localparam int STAT_CONV_BIT = 2;
   localparam int STAT_RELEASE_BIT = 3;
   localparam int STAT_STANDBY_BIT = 4;
   // Channel codes
   localparam logic [1:0] CHAN_SUPPLY = 2'h0;
   localparam logic [1:0] CHAN_INTERNAL = 2'h1;
   localparam logic [1:0] CHAN_EXTERNAL = 2'h2;
   // Averaging and timing
   localparam int AVG_COUNT = 16;
   localparam int DAC_BITS_DEFAULT = 12;
   localparam int CLOCK_KHZ = 100000;
   localparam int TIMEOUT_MS = 25;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLOCK_KHZ;
   typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage

/* File: shared/conv_seq_if.sv */
// Link between the register block and the conversion sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface conv_seq_if;
   logic run;
   logic singleMode;
   logic avgOn;
   logic softReset;
   logic [1:0] chanSel;
   logic convDone;
   logic [1:0] chan;
   logic resultValid;
   logic convEnable;
   modport ctrl (output run, singleMode, avgOn, softReset, chanSel, convDone,
      input chan, resultValid, convEnable);
   modport seq (input run, singleMode, avgOn, softReset, chanSel, convDone,
      output chan, resultValid, convEnable);
endinterface
`default_nettype wire

/* File: design/conv_sequencer.sv */
// Channel sequencer: round robin or single channel, with averaging.
// Assumes convDone is a one-cycle pulse from the converter, same clock.
`timescale 1ns/100ps
`default_nettype none
module conv_sequencer #(
   parameter int AVG_DEPTH = dac_monitor_pkg::AVG_COUNT
) (
   input wire logic clock,
   input wire logic reset_n,
   conv_seq_if.seq link
);
   import dac_monitor_pkg::*;
   localparam int CW = $clog2(AVG_DEPTH);
   localparam logic [CW-1:0] LAST = CW'(AVG_DEPTH - 1);

   initial begin
      if (AVG_DEPTH < 2) $error("AVG_DEPTH must be at least 2");
   end

   typedef struct packed {
      seq_state_t state;
      logic [1:0] chan;
      logic [CW-1:0] avgCnt;
      logic resultValid;
   } seq_t;

   seq_t st_r, st_nxt;

   // Reserved code falls back to the supply channel
   function automatic logic [1:0] legalChan(input logic [1:0] c);
      return (c == 2'h3) ? CHAN_SUPPLY : c;
   endfunction

   always_comb begin
      st_nxt = st_r;
      st_nxt.resultValid = 1'b0;
      if (link.softReset || !link.run) begin
         st_nxt.state = SEQ_IDLE;
         st_nxt.chan = CHAN_SUPPLY;
         st_nxt.avgCnt = '0;
      end else begin
         unique case (st_r.state)
            SEQ_IDLE: begin
               st_nxt.state = SEQ_RUN;
               st_nxt.avgCnt = '0;
               st_nxt.chan = link.singleMode ? legalChan(link.chanSel) : CHAN_SUPPLY;
            end
            SEQ_RUN: begin
               if (link.singleMode) begin
                  st_nxt.chan = legalChan(link.chanSel);
               end
               if (link.convDone) begin
                  if (!link.avgOn || st_r.avgCnt == LAST) begin
                     st_nxt.resultValid = 1'b1;
                     st_nxt.avgCnt = '0;
                     if (!link.singleMode) begin
                        st_nxt.chan = (st_r.chan == CHAN_EXTERNAL) ? CHAN_SUPPLY :
                           st_r.chan + 2'h1;
                     end
                  end else begin
                     st_nxt.avgCnt = st_r.avgCnt + 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{state: SEQ_IDLE, chan: 2'h0, avgCnt: '0, resultValid: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.chan = st_r.chan;
   assign link.resultValid = st_r.resultValid;
   assign link.convEnable = (st_r.state == SEQ_RUN);

   avg_result_a: assert property (@(posedge clock) disable iff (!reset_n)
      link.resultValid && link.avgOn && $past(link.avgOn) && $past(link.run)
      |-> $past(st_r.avgCnt) == LAST)
      else $error("result issued before the averaging count");
   robin_step_a: assert property (@(posedge clock) disable iff (!reset_n)
      link.resultValid && !$past(link.singleMode) && $past(link.run)
      && !$past(link.softReset) && $past(st_r.chan) == CHAN_SUPPLY
      |-> link.chan == CHAN_INTERNAL)
      else $error("round robin did not advance to the internal sensor");
endmodule // conv_sequencer
`default_nettype wire

/* File: design/scl_timeout.sv */
// Serial clock low timeout; releases the data line after the limit.
// Assumes sclIn is an asynchronous pin level.
`timescale 1ns/100ps
`default_nettype none
module scl_timeout #(
   parameter int LIMIT_CYCLES = dac_monitor_pkg::TIMEOUT_CYCLES
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic softReset,
   input wire logic sclIn,
   output logic sdaRelease
);
   import dac_monitor_pkg::*;
   localparam int CW = $clog2(LIMIT_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(LIMIT_CYCLES - 1);

   initial begin
      if (LIMIT_CYCLES < 2) $error("LIMIT_CYCLES must be at least 2");
   end

   typedef struct packed {
      logic [2:0] sync;
      logic sclLevel;
      logic [CW-1:0] count;
      logic release_;
   } tmo_t;

   tmo_t st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.sync = {st_r.sync[1:0], sclIn};
      // Level moves only once second and third stages agree
      if (st_r.sync[1] == st_r.sync[2]) begin
         st_nxt.sclLevel = st_r.sync[2];
      end
      if (!enable || softReset || st_r.sclLevel) begin
         st_nxt.count = '0;
         st_nxt.release_ = 1'b0;
      end else if (st_r.count == LAST) begin
         st_nxt.release_ = 1'b1;
      end else begin
         st_nxt.count = st_r.count + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{sync: 3'h7, sclLevel: 1'b1, count: '0, release_: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sdaRelease = st_r.release_;

   release_cause_a: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(sdaRelease) |-> $past(st_r.count) == LAST && $past(enable))
      else $error("data line released before the timeout limit");
   timeout_off_a: assert property (@(posedge clock) disable iff (!reset_n)
      !enable |=> !sdaRelease)
      else $error("data line released with timeout disabled");
endmodule // scl_timeout
`default_nettype wire

/* File: design/dac_monitor_control_regs.sv */
// Channel D word and mode configuration registers behind an APB slave.
// Assumes an APB master on the same clock and converter strobes on it too.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dac_monitor_control_regs #(
   parameter int DAC_BITS = dac_monitor_pkg::DAC_BITS_DEFAULT,
   parameter int TIMEOUT_LIMIT = dac_monitor_pkg::TIMEOUT_CYCLES
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [dac_monitor_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dac_monitor_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [dac_monitor_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic convDone,
   input wire logic monitorAlert,
   input wire logic sclIn,
   output logic sdaRelease,
   output logic [DAC_BITS-1:0] analogOutChannelD,
   output logic standbyRequest,
   output logic convEnable,
   output logic [1:0] convChannel,
   output logic resultValid,
   output logic averagingOn,
   output logic intOut
);
   import dac_monitor_pkg::*;

   initial begin
      if (DAC_BITS != 8 && DAC_BITS != 10 && DAC_BITS != 12) begin
         $error("DAC_BITS must be 8, 10 or 12");
      end
   end

   // Unused low bits of the low word read back as zero
   localparam logic [7:0] LOW_MASK = 8'(16'h00FF << (16 - DAC_BITS));

   typedef struct packed {
      logic [7:0] dacLow;
      logic [7:0] dacHigh;
      logic [7:0] cfgOne;
      logic [7:0] cfgTwo;
      logic [DATA_W-1:0] rdData;
      logic intLevel;
   } regs_t;

   regs_t st_r, st_nxt;
   conv_seq_if seqLink ();

   logic setupPhase;
   logic accessPhase;
   logic writeHit;
   logic swReset;
   logic [7:0] readByte;
   logic [7:0] statusByte;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a == ADDR_DAC_D_LOW || a == ADDR_DAC_D_HIGH || a == ADDR_MODE_CFG_ONE ||
         a == ADDR_MODE_CFG_TWO || a == ADDR_STATUS;
   endfunction

   function automatic logic intActiveLevel(input logic [7:0] cfg, input logic alert);
      logic active;
      active = alert && !cfg[CFG1_INT_DISABLE_BIT];
      return active ? cfg[CFG1_INT_POLARITY_BIT] : !cfg[CFG1_INT_POLARITY_BIT];
   endfunction

   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign writeHit = accessPhase && pwrite && pstrb[0];
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = accessPhase && !mapped(paddr);
   assign swReset = writeHit && paddr == ADDR_MODE_CFG_TWO && pwdata[CFG2_SWRESET_BIT];

   always_comb begin
      statusByte = 8'h00;
      statusByte[STAT_CHAN_LSB +: 2] = seqLink.chan;
      statusByte[STAT_CONV_BIT] = seqLink.convEnable;
      statusByte[STAT_RELEASE_BIT] = sdaRelease;
      statusByte[STAT_STANDBY_BIT] = st_r.cfgOne[CFG1_STANDBY_BIT];
   end

   always_comb begin
      unique case (paddr)
         ADDR_DAC_D_LOW: readByte = st_r.dacLow;
         ADDR_DAC_D_HIGH: readByte = st_r.dacHigh;
         ADDR_MODE_CFG_ONE: readByte = st_r.cfgOne;
         ADDR_MODE_CFG_TWO: readByte = st_r.cfgTwo;
         ADDR_STATUS: readByte = statusByte;
         default: readByte = 8'h00;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      // Read data is caught in setup so prdata comes from a flop
      if (setupPhase && !pwrite) begin
         st_nxt.rdData = {24'h000000, readByte};
      end
      if (swReset) begin
         st_nxt.dacLow = RST_DAC_D_LOW;
         st_nxt.dacHigh = RST_DAC_D_HIGH;
         st_nxt.cfgOne = RST_MODE_CFG_ONE;
         st_nxt.cfgTwo = RST_MODE_CFG_TWO;
      end else if (writeHit) begin
         unique case (paddr)
            ADDR_DAC_D_LOW: st_nxt.dacLow = pwdata[7:0] & LOW_MASK;
            ADDR_DAC_D_HIGH: st_nxt.dacHigh = pwdata[7:0];
            // Reserved bits are stored as written; host keeps them zero
            ADDR_MODE_CFG_ONE: st_nxt.cfgOne = pwdata[7:0];
            ADDR_MODE_CFG_TWO: st_nxt.cfgTwo = pwdata[7:0];
            default: st_nxt.cfgTwo = st_r.cfgTwo;
         endcase
      end
      // Register the pin so it never glitches on a config write
      st_nxt.intLevel = intActiveLevel(st_nxt.cfgOne, monitorAlert);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{dacLow: RST_DAC_D_LOW, dacHigh: RST_DAC_D_HIGH,
            cfgOne: RST_MODE_CFG_ONE, cfgTwo: RST_MODE_CFG_TWO,
            rdData: '0, intLevel: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdData;
   assign intOut = st_r.intLevel;
   // Code is held through standby so outputs return unchanged on wake
   assign analogOutChannelD = DAC_BITS'({st_r.dacHigh, st_r.dacLow} >> (16 - DAC_BITS));
   assign standbyRequest = st_r.cfgOne[CFG1_STANDBY_BIT];
   assign averagingOn = !st_r.cfgTwo[CFG2_AVG_OFF_BIT];

   // Converter runs only when monitoring and not in standby
   assign seqLink.run = st_r.cfgOne[CFG1_MONITOR_BIT] && !standbyRequest;
   assign seqLink.singleMode = st_r.cfgTwo[CFG2_SINGLE_BIT];
   assign seqLink.avgOn = averagingOn;
   assign seqLink.softReset = swReset;
   assign seqLink.chanSel = st_r.cfgTwo[CFG2_CHAN_LSB +: 2];
   assign seqLink.convDone = convDone;
   assign convEnable = seqLink.convEnable;
   assign convChannel = seqLink.chan;
   assign resultValid = seqLink.resultValid;

   conv_sequencer #(
      .AVG_DEPTH(AVG_COUNT)
   ) sequencer (
      .clock(clock),
      .reset_n(reset_n),
      .link(seqLink)
   );

   scl_timeout #(
      .LIMIT_CYCLES(TIMEOUT_LIMIT)
   ) timeout (
      .clock(clock),
      .reset_n(reset_n),
      .enable(st_r.cfgTwo[CFG2_TIMEOUT_BIT]),
      .softReset(swReset),
      .sclIn(sclIn),
      .sdaRelease(sdaRelease)
   );

   low_mask_a: assert property (@(posedge clock) disable iff (!reset_n)
      (st_r.dacLow & ~LOW_MASK) == 8'h00)
      else $error("unused low DAC bits are set");
   code_join_a: assert property (@(posedge clock) disable iff (!reset_n)
      writeHit && !swReset && paddr == ADDR_DAC_D_HIGH
      |=> analogOutChannelD[DAC_BITS-1 -: 8] == $past(pwdata[7:0]))
      else $error("high DAC bits not on the output code");
   monitor_start_a: assert property (@(posedge clock) disable iff (!reset_n)
      !st_r.cfgOne[CFG1_MONITOR_BIT] |=> !convEnable)
      else $error("conversions running while monitoring is stopped");
   int_disable_a: assert property (@(posedge clock) disable iff (!reset_n)
      $past(st_r.cfgOne[CFG1_INT_DISABLE_BIT]) && st_r.cfgOne == $past(st_r.cfgOne)
      |-> intOut == !st_r.cfgOne[CFG1_INT_POLARITY_BIT])
      else $error("interrupt asserted while disabled");
   int_polarity_a: assert property (@(posedge clock) disable iff (!reset_n)
      monitorAlert && !st_nxt.cfgOne[CFG1_INT_DISABLE_BIT]
      |=> intOut == st_r.cfgOne[CFG1_INT_POLARITY_BIT])
      else $error("interrupt level does not follow polarity");
   standby_stop_a: assert property (@(posedge clock) disable iff (!reset_n)
      standbyRequest ##1 standbyRequest |-> !convEnable)
      else $error("converter active during standby");
   single_chan_a: assert property (@(posedge clock) disable iff (!reset_n)
      convEnable && $past(convEnable) && seqLink.singleMode && $past(seqLink.singleMode)
      && $past(seqLink.chanSel) != 2'h3 |-> convChannel == $past(seqLink.chanSel))
      else $error("single channel mode converting the wrong channel");
   avg_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
      writeHit && !swReset && paddr == ADDR_MODE_CFG_TWO
      |=> averagingOn == !$past(pwdata[CFG2_AVG_OFF_BIT]))
      else $error("averaging flag does not follow its bit");
   soft_reset_a: assert property (@(posedge clock) disable iff (!reset_n)
      swReset |=> st_r.cfgOne == RST_MODE_CFG_ONE && analogOutChannelD == '0
      && st_r.cfgTwo == RST_MODE_CFG_TWO)
      else $error("software reset left a register set");
   read_back_a: assert property (@(posedge clock) disable iff (!reset_n)
      setupPhase && !pwrite && paddr == ADDR_MODE_CFG_ONE
      |=> prdata == {24'h000000, $past(st_r.cfgOne)})
      else $error("read data does not match the register");
endmodule // dac_monitor_control_regs
`default_nettype wire

/* File: dv/conv_partner.sv */
// Converter and serial clock stand-in facing the register block.
// Assumes one clock; convDone pulses every GAP cycles while enabled.
`timescale 1ns/100ps
`default_nettype none
module conv_partner #(
   parameter int GAP = 4
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic convEnable,
   input wire logic sclHold,
   output logic convDone,
   output logic sclIn
);
   int cnt;
   // Pulled-up clock line; only a stuck host holds it low
   assign sclIn = !sclHold;
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 0;
         convDone <= 1'h0;
      end else begin
         cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
         convDone <= convEnable && (cnt == GAP - 1);
      end
   end
endmodule // conv_partner
`default_nettype wire

/* File: dv/dac_monitor_control_regs_test.sv */
// Self-checking bench for the channel D word and mode configuration registers.
// Assumes a zero or more wait state APB slave and the converter partner model.
`timescale 1ns/100ps
`default_nettype none
module dac_monitor_control_regs_test;
   import dac_monitor_pkg::*;
   localparam int DBITS = 12;
   localparam int LIM = 20;
   localparam logic [7:0] LOWMASK = 8'hFF << (16 - DBITS);
   logic clock, reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic convDone, monitorAlert, sclIn, sclHold, sdaRelease, standbyRequest;
   logic convEnable, resultValid, averagingOn, intOut;
   logic [1:0] convChannel, ch1, ch2;
   logic [1:0] chans [3] = '{CHAN_SUPPLY, CHAN_INTERNAL, CHAN_EXTERNAL};
   logic [DBITS-1:0] analogOutChannelD;
   int error_cnt = 0, tests_run = 0, cycles = 0, doneCnt = 0, lastCnt = 0;

   dac_monitor_control_regs #(.DAC_BITS(DBITS), .TIMEOUT_LIMIT(LIM)) u_dut (.clock(clock),
      .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .convDone(convDone), .monitorAlert(monitorAlert), .sclIn(sclIn),
      .sdaRelease(sdaRelease), .analogOutChannelD(analogOutChannelD),
      .standbyRequest(standbyRequest), .convEnable(convEnable), .convChannel(convChannel),
      .resultValid(resultValid), .averagingOn(averagingOn), .intOut(intOut));
   conv_partner u_partner (.clock(clock), .reset_n(reset_n), .convEnable(convEnable),
      .sclHold(sclHold), .convDone(convDone), .sclIn(sclIn));

   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   // Counts converter strobes per result; cleared while idle
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (!convEnable) doneCnt <= 0;
      else if (resultValid) begin
         lastCnt <= doneCnt + int'(convDone);
         doneCnt <= 0;
      end else doneCnt <= doneCnt + int'(convDone);
      if (cycles == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 50);
      // A slave that never answers counts as a mismatch
      if (pready !== 1'h1) error_cnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic waitCyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Bounded wait for one result pulse, then the channel it moved on to
   task automatic waitRes(output logic [1:0] ch);
      int n;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (resultValid !== 1'h1 && n < 400);
      if (resultValid !== 1'h1) error_cnt++;
      @(negedge clock);
      ch = convChannel;
   endtask
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      reset_n = 1'h0;
      {psel, penable, pwrite, monitorAlert, sclHold} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      repeat (5) @(posedge clock);
      reset_n <= 1'h1;
      rdchk("dacLow", ADDR_DAC_D_LOW, 32'h0);
      rdchk("dacHigh", ADDR_DAC_D_HIGH, 32'h0);
      rdchk("cfgOne", ADDR_MODE_CFG_ONE, 32'h0);
      rdchk("cfgTwo", ADDR_MODE_CFG_TWO, 32'h0);
      chk("dacOut", 32'h0, 32'(analogOutChannelD));
      chk("intIdle", 32'h1, 32'(intOut));
      $display("Test reset done");
      wr(ADDR_DAC_D_LOW, 32'hFF);
      wr(ADDR_DAC_D_HIGH, 32'hA5);
      rdchk("dacLow", ADDR_DAC_D_LOW, 32'(LOWMASK));
      rdchk("dacHigh", ADDR_DAC_D_HIGH, 32'hA5);
      chk("dacOut", 32'({8'hA5, LOWMASK} >> (16 - DBITS)), 32'(analogOutChannelD));
      apb(1'h0, 8'h04, 32'h0);
      chk("errFlag", 32'h1, 32'(err));
      chk("errData", 32'h0, rd);
      // Write without the low byte strobe must not land
      pstrb <= 4'hE;
      wr(ADDR_DAC_D_HIGH, 32'h11);
      pstrb <= 4'hF;
      rdchk("noStrobe", ADDR_DAC_D_HIGH, 32'hA5);
      $display("Test dac word done");
      @(posedge clock) monitorAlert <= 1'h1;
      waitCyc(3);
      chk("intLow", 32'h0, 32'(intOut));
      wr(ADDR_MODE_CFG_ONE, 32'h40);
      waitCyc(3);
      chk("intHigh", 32'h1, 32'(intOut));
      wr(ADDR_MODE_CFG_ONE, 32'h60);
      waitCyc(3);
      chk("intOff", 32'h0, 32'(intOut));
      wr(ADDR_MODE_CFG_ONE, 32'h81);
      waitCyc(3);
      chk("standby", 32'h1, 32'(standbyRequest));
      chk("convStop", 32'h0, 32'(convEnable));
      wr(ADDR_MODE_CFG_ONE, 32'h00);
      waitCyc(3);
      chk("standby", 32'h0, 32'(standbyRequest));
      $display("Test interrupt and standby done");
      wr(ADDR_MODE_CFG_ONE, 32'h01);
      waitCyc(3);
      chk("convRun", 32'h1, 32'(convEnable));
      chk("avgOn", 32'h1, 32'(averagingOn));
      waitRes(ch1);
      chk("avgCount", 32'd16, 32'(lastCnt));
      chk("robinFirst", 32'(CHAN_INTERNAL), 32'(ch1));
      waitRes(ch2);
      chk("avgCount", 32'd16, 32'(lastCnt));
      chk("robin", 32'((ch1 == 2'h2) ? 2'h0 : ch1 + 2'h1), 32'(ch2));
      wr(ADDR_MODE_CFG_ONE, 32'h00);
      waitCyc(3);
      chk("convRun", 32'h0, 32'(convEnable));
      wr(ADDR_MODE_CFG_TWO, 32'h20);
      wr(ADDR_MODE_CFG_ONE, 32'h01);
      waitCyc(3);
      chk("avgOn", 32'h0, 32'(averagingOn));
      waitRes(ch1);
      waitRes(ch2);
      chk("avgCount", 32'd1, 32'(lastCnt));
      chk("robin", 32'((ch1 == 2'h2) ? 2'h0 : ch1 + 2'h1), 32'(ch2));
      for (int c = 0; c < 3; c++) begin
         wr(ADDR_MODE_CFG_TWO, 32'h30 | 32'(chans[c]));
         waitRes(ch1);
         waitRes(ch1);
         chk("single", 32'(chans[c]), 32'(ch1));
      end
      $display("Test conversion modes done");
      wr(ADDR_MODE_CFG_TWO, 32'h00);
      @(posedge clock) sclHold <= 1'h1;
      waitCyc(LIM + 10);
      chk("noRelease", 32'h0, 32'(sdaRelease));
      wr(ADDR_MODE_CFG_TWO, 32'h40);
      waitCyc(LIM + 6);
      chk("release", 32'h1, 32'(sdaRelease));
      @(posedge clock) sclHold <= 1'h0;
      waitCyc(8);
      chk("freed", 32'h0, 32'(sdaRelease));
      $display("Test clock timeout done");
      wr(ADDR_DAC_D_LOW, 32'hFF);
      wr(ADDR_DAC_D_HIGH, 32'h5A);
      wr(ADDR_MODE_CFG_ONE, 32'hE1);
      wr(ADDR_MODE_CFG_TWO, 32'h80);
      waitCyc(2);
      chk("dacOut", 32'h0, 32'(analogOutChannelD));
      chk("convRun", 32'h0, 32'(convEnable));
      rdchk("dacLow", ADDR_DAC_D_LOW, 32'h0);
      rdchk("dacHigh", ADDR_DAC_D_HIGH, 32'h0);
      rdchk("cfgOne", ADDR_MODE_CFG_ONE, 32'h0);
      rdchk("cfgTwo", ADDR_MODE_CFG_TWO, 32'h0);
      $display("Test software reset done");
      wrap_up();
   end
endmodule // dac_monitor_control_regs_test
`default_nettype wire
